// >>> hdl/servo_velocity_torque_io_objects.sv
module servo_velocity_torque_io_objects (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire servo_io_pkg::obj_req_t req,
  output logic [31:0]                 rdata,
  output logic                        rvalid,
  output logic                        rerr,
  input  wire servo_io_pkg::mode_t    mode,
  input  wire logic signed [31:0]     encoder_speed_in,
  input  wire logic signed [31:0]     motor_speed_in,
  input  wire logic signed [31:0]     trajectory_speed_in,
  input  wire logic signed [31:0]     position_loop_speed_in,
  input  wire servo_io_pkg::pin_in_t  pins_in,
  input  wire logic [7:0]             input_allocation_low,
  input  wire logic [7:0]             input_allocation_high,
  input  wire logic [3:0]             remote_output_allocation,
  input  wire logic [3:0]             bus_output_enable_low,
  input  wire logic [3:0]             bus_output_enable_high,
  input  wire logic [3:0]             output_invert_low,
  input  wire logic [3:0]             output_invert_high,
  output logic [15:0]                 statusword_bits,
  output logic signed [15:0]          torque_command,
  output logic [15:0]                 torque_limit_fwd,
  output logic [15:0]                 torque_limit_rev,
  output logic [2:0]                  internal_switches,
  output logic [4:0]                  internal_conn_in,
  output logic [3:0]                  conn_out,
  output logic [3:0]                  remote_out
);
  import servo_io_pkg::*;

  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  function automatic logic [15:0] umin16(input logic [15:0] a, input logic [15:0] b);
    umin16 = (a < b) ? a : b;
  endfunction

  function automatic logic [31:0] sabs33(input logic signed [32:0] v);
    logic signed [32:0] n;
    n = -v;
    sabs33 = (v < 0) ? n[31:0] : v[31:0];
  endfunction

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  // pins are asynchronous to core_clk; only the second stage is read
  pin_in_t pins_s1_r;
  pin_in_t pins_s2_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins_s1_r <= '0;
      pins_s2_r <= '0;
    end else begin
      pins_s1_r <= pins_in;
      pins_s2_r <= pins_s1_r;
    end
  end

  // -----------------------------------------------------------------
  // writable objects
  // -----------------------------------------------------------------
  logic [15:0]        match_width_r;
  logic [15:0]        match_time_r;
  logic [15:0]        threshold_r;
  logic [15:0]        threshold_time_r;
  logic signed [15:0] torque_setpoint_r;
  logic [15:0]        torque_ceiling_r;
  logic [31:0]        ramp_rate_r;
  logic [15:0]        limit_fwd_r;
  logic [15:0]        limit_rev_r;
  logic [31:0]        output_word_r;
  logic [31:0]        output_mask_r;
  logic signed [31:0] speed_setpoint_r;

  // single-entry objects take writes on subindex 0 only
  wire wr_sub0 = req.wr && (req.sub == SUB_ENTRY_COUNT);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_width_r     <= '0;
      match_time_r      <= '0;
      threshold_r       <= '0;
      threshold_time_r  <= '0;
      torque_setpoint_r <= '0;
      torque_ceiling_r  <= TORQUE_CEILING_RST;
      ramp_rate_r       <= TORQUE_RAMP_RST;
      limit_fwd_r       <= TORQUE_LIMIT_RST;
      limit_rev_r       <= TORQUE_LIMIT_RST;
      output_word_r     <= '0;
      output_mask_r     <= '0;
      speed_setpoint_r  <= '0;
    end else if (req.wr) begin
      case (req.index)
        IDX_SPEED_MATCH_WIDTH: if (wr_sub0) match_width_r <= req.wdata[15:0];
        IDX_SPEED_MATCH_TIME:  if (wr_sub0) match_time_r <= req.wdata[15:0];
        IDX_SPEED_THRESHOLD:   if (wr_sub0) threshold_r <= req.wdata[15:0];
        IDX_SPEED_THRESH_TIME: if (wr_sub0) threshold_time_r <= req.wdata[15:0];
        IDX_TORQUE_SETPOINT:   if (wr_sub0) torque_setpoint_r <= req.wdata[15:0];
        IDX_TORQUE_CEILING:    if (wr_sub0) torque_ceiling_r <= req.wdata[15:0];
        IDX_TORQUE_RAMP_RATE:  if (wr_sub0) ramp_rate_r <= req.wdata;
        IDX_TORQUE_LIMIT_FWD:  if (wr_sub0) limit_fwd_r <= req.wdata[15:0];
        IDX_TORQUE_LIMIT_REV:  if (wr_sub0) limit_rev_r <= req.wdata[15:0];
        IDX_SPEED_SETPOINT:    if (wr_sub0) speed_setpoint_r <= req.wdata;
        IDX_OUTPUT_OBJ: begin
          if (req.sub == SUB_OUTPUT_WORD) output_word_r <= req.wdata & WRITABLE_OUT_MASK;
          if (req.sub == SUB_OUTPUT_MASK) output_mask_r <= req.wdata & WRITABLE_OUT_MASK;
        end
        default: ;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // speed qualification timers
  // -----------------------------------------------------------------
  logic [17:0] match_div_r;
  logic [17:0] over_div_r;
  logic [15:0] match_ms_r;
  logic [15:0] over_ms_r;
  logic        match_flag_r;
  logic        over_flag_r;
  wire         match_tick = (match_div_r == 18'(MS_CYCLES - 1));
  wire         over_tick  = (over_div_r == 18'(MS_CYCLES - 1));
  wire [31:0]  speed_err = sabs33(33'(speed_setpoint_r) - 33'(motor_speed_in));
  wire         in_window = (speed_err <= {16'h0000, match_width_r});
  wire         over_thr  = (motor_speed_in > $signed({16'h0000, threshold_r}));

  // each timer keeps its own millisecond divider and restarts it with the
  // count, so a hold time never comes out short by a partial millisecond
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      match_div_r  <= '0;
      match_ms_r   <= '0;
      match_flag_r <= 1'b0;
    end else if (!in_window) begin
      match_div_r  <= '0;
      match_ms_r   <= '0;
      match_flag_r <= 1'b0;
    end else if (match_ms_r >= match_time_r) begin
      match_flag_r <= 1'b1;
    end else begin
      match_div_r <= match_tick ? '0 : match_div_r + 18'd1;
      if (match_tick) match_ms_r <= match_ms_r + 16'd1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      over_div_r  <= '0;
      over_ms_r   <= '0;
      over_flag_r <= 1'b0;
    end else if (!over_thr) begin
      over_div_r  <= '0;
      over_ms_r   <= '0;
      over_flag_r <= 1'b0;
    end else if (over_ms_r >= threshold_time_r) begin
      over_flag_r <= 1'b1;
    end else begin
      over_div_r <= over_tick ? '0 : over_div_r + 18'd1;
      if (over_tick) over_ms_r <= over_ms_r + 16'd1;
    end
  end

  always_comb begin
    statusword_bits = '0;
    statusword_bits[STATUS_SPEED_MATCH_BIT] = match_flag_r;
    statusword_bits[STATUS_SPEED_OVER_BIT]  = over_flag_r;
  end

  // -----------------------------------------------------------------
  // torque reference and limits
  // -----------------------------------------------------------------
  logic signed [15:0] torque_out_r;
  logic [31:0]        ramp_acc_r;
  // limits come straight from the registers, so a change acts at once
  wire  [15:0]        lim_fwd = umin16(torque_ceiling_r, limit_fwd_r);
  wire  [15:0]        lim_rev = umin16(torque_ceiling_r, limit_rev_r);
  wire  signed [17:0] cap_hi = (mode == MODE_PROFILE_TORQUE) ?
                               $signed({2'b00, umin16(lim_fwd, torque_ceiling_r)}) :
                               $signed({2'b00, lim_fwd});
  wire  signed [17:0] cap_lo = -$signed({2'b00, lim_rev});
  wire  signed [17:0] sp_ext = 18'(torque_setpoint_r);
  wire  signed [17:0] target = (sp_ext > cap_hi) ? cap_hi :
                               (sp_ext < cap_lo) ? cap_lo : sp_ext;
  wire  signed [17:0] cur    = 18'(torque_out_r);
  // slope accumulated per cycle; one unit moves when it passes a second's worth
  // limitation: one unit per cycle is the steepest ramp, faster slopes clip there
  wire                fast    = (ramp_rate_r >= 32'(CLK_HZ));
  wire  [33:0]        acc_sum = 34'(ramp_acc_r) + 34'(ramp_rate_r);
  wire                step    = fast || (acc_sum >= 34'(CLK_HZ));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      torque_out_r <= '0;
      ramp_acc_r   <= '0;
    end else if (mode != MODE_PROFILE_TORQUE) begin
      // outside profile torque the clamped setpoint passes straight through
      torque_out_r <= target[15:0];
      ramp_acc_r   <= '0;
    end else if (cur == target) begin
      ramp_acc_r   <= '0;
    end else begin
      // a clipped slope would only grow the remainder until it wrapped
      if (fast) ramp_acc_r <= '0;
      else ramp_acc_r <= step ? 32'(acc_sum - 34'(CLK_HZ)) : acc_sum[31:0];
      if (step) torque_out_r <= (cur < target) ? torque_out_r + 16'sd1 : torque_out_r - 16'sd1;
    end
  end

  assign torque_command   = torque_out_r;
  assign torque_limit_fwd = lim_fwd;
  assign torque_limit_rev = lim_rev;

  // -----------------------------------------------------------------
  // digital inputs and outputs
  // -----------------------------------------------------------------
  logic [31:0] input_word;
  logic [3:0]  conn_out_r;
  logic [3:0]  remote_out_r;
  // either allocation word can claim an input for the master
  wire  [7:0]  in_remote = input_allocation_low | input_allocation_high;

  always_comb begin
    input_word = '0;
    input_word[IN_NEG_OT_BIT] = pins_s2_r.neg_ot;
    input_word[IN_POS_OT_BIT] = pins_s2_r.pos_ot;
    input_word[IN_HOME_BIT]   = pins_s2_r.home;
    input_word[IN_CONN_LSB +: CONN_IN_COUNT] = pins_s2_r.conn;
  end

  // remote-assigned inputs read as idle so internal functions never see them
  assign internal_switches = {pins_s2_r.home, pins_s2_r.pos_ot, pins_s2_r.neg_ot}
                             & ~in_remote[2:0];
  assign internal_conn_in  = pins_s2_r.conn | in_remote[7:3];

  // a disabled connector output parks at the inactive level
  genvar gi;
  generate
    for (gi = 0; gi < CONN_OUT_COUNT; gi++) begin : g_out
      wire en_c = output_mask_r[OUT_CONN_LSB + gi] &&
                  (bus_output_enable_low[gi] | bus_output_enable_high[gi]);
      wire inv  = output_invert_low[gi] ^ output_invert_high[gi];
      wire en_r = output_mask_r[OUT_REMOTE_LSB + gi] && remote_output_allocation[gi];
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          conn_out_r[gi]   <= 1'b1;
          remote_out_r[gi] <= 1'b0;
        end else begin
          // 1 on the pin means switched off and inactive
          conn_out_r[gi] <= en_c ? (output_word_r[OUT_CONN_LSB + gi] ^ inv) : 1'b1;
          remote_out_r[gi] <= en_r ? output_word_r[OUT_REMOTE_LSB + gi] : 1'b0;
        end
      end
    end
  endgenerate

  assign conn_out   = conn_out_r;
  assign remote_out = remote_out_r;

  // -----------------------------------------------------------------
  // object read port
  // -----------------------------------------------------------------
  logic [31:0] rd_nxt;
  logic        err_nxt;

  always_comb begin
    rd_nxt  = '0;
    err_nxt = (req.sub != SUB_ENTRY_COUNT);
    case (req.index)
      IDX_ENCODER_SPEED:     rd_nxt = encoder_speed_in;
      IDX_SPEED_LOOP_REF:    rd_nxt = (mode == MODE_POSITION) ? position_loop_speed_in
                                                              : trajectory_speed_in;
      IDX_MOTOR_SPEED:       rd_nxt = motor_speed_in;
      IDX_SPEED_MATCH_WIDTH: rd_nxt = {16'h0000, match_width_r};
      IDX_SPEED_MATCH_TIME:  rd_nxt = {16'h0000, match_time_r};
      IDX_SPEED_THRESHOLD:   rd_nxt = {16'h0000, threshold_r};
      IDX_SPEED_THRESH_TIME: rd_nxt = {16'h0000, threshold_time_r};
      IDX_TORQUE_SETPOINT:   rd_nxt = 32'(torque_setpoint_r);
      IDX_TORQUE_CEILING:    rd_nxt = {16'h0000, torque_ceiling_r};
      IDX_TORQUE_REF_OUT:    rd_nxt = 32'(torque_out_r);
      IDX_TORQUE_FEEDBACK:   rd_nxt = 32'(torque_out_r);
      IDX_TORQUE_RAMP_RATE:  rd_nxt = ramp_rate_r;
      IDX_TORQUE_LIMIT_FWD:  rd_nxt = {16'h0000, limit_fwd_r};
      IDX_TORQUE_LIMIT_REV:  rd_nxt = {16'h0000, limit_rev_r};
      IDX_INPUT_WORD:        rd_nxt = input_word;
      IDX_SPEED_SETPOINT:    rd_nxt = speed_setpoint_r;
      IDX_OUTPUT_OBJ: begin
        err_nxt = (req.sub > SUB_OUTPUT_MASK);
        case (req.sub)
          SUB_ENTRY_COUNT: rd_nxt = {24'h000000, OUTPUT_ENTRY_COUNT};
          SUB_OUTPUT_WORD: rd_nxt = output_word_r;
          SUB_OUTPUT_MASK: rd_nxt = output_mask_r;
          default:         rd_nxt = '0;
        endcase
      end
      default: err_nxt = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata  <= '0;
      rvalid <= 1'b0;
      rerr   <= 1'b0;
    end else begin
      // a same-cycle write is not visible yet: the read returns the old value
      rvalid <= req.rd;
      rerr   <= req.rd && err_nxt;
      rdata  <= (req.rd && !err_nxt) ? rd_nxt : '0;
    end
  end
endmodule

// >>> hdl/servo_io_pkg.sv
package servo_io_pkg;
  // -----------------------------------------------------------------
  // object indices
  // -----------------------------------------------------------------
  localparam logic [15:0] IDX_ENCODER_SPEED      = 16'h6069;
  localparam logic [15:0] IDX_SPEED_LOOP_REF     = 16'h606B;
  localparam logic [15:0] IDX_MOTOR_SPEED        = 16'h606C;
  localparam logic [15:0] IDX_SPEED_MATCH_WIDTH  = 16'h606D;
  localparam logic [15:0] IDX_SPEED_MATCH_TIME   = 16'h606E;
  localparam logic [15:0] IDX_SPEED_THRESHOLD    = 16'h606F;
  localparam logic [15:0] IDX_SPEED_THRESH_TIME  = 16'h6070;
  localparam logic [15:0] IDX_TORQUE_SETPOINT    = 16'h6071;
  localparam logic [15:0] IDX_TORQUE_CEILING     = 16'h6072;
  localparam logic [15:0] IDX_TORQUE_REF_OUT     = 16'h6074;
  localparam logic [15:0] IDX_TORQUE_FEEDBACK    = 16'h6077;
  localparam logic [15:0] IDX_TORQUE_RAMP_RATE   = 16'h6087;
  localparam logic [15:0] IDX_TORQUE_LIMIT_FWD   = 16'h60E0;
  localparam logic [15:0] IDX_TORQUE_LIMIT_REV   = 16'h60E1;
  localparam logic [15:0] IDX_INPUT_WORD         = 16'h60FD;
  localparam logic [15:0] IDX_OUTPUT_OBJ         = 16'h60FE;
  localparam logic [15:0] IDX_SPEED_SETPOINT     = 16'h60FF;
  localparam logic [7:0]  SUB_ENTRY_COUNT        = 8'h00;
  localparam logic [7:0]  SUB_OUTPUT_WORD        = 8'h01;
  localparam logic [7:0]  SUB_OUTPUT_MASK        = 8'h02;
  // -----------------------------------------------------------------
  // entry count and reset values
  // -----------------------------------------------------------------
  localparam logic [7:0]  OUTPUT_ENTRY_COUNT     = 8'h02;
  localparam logic [15:0] TORQUE_CEILING_RST     = 16'h0BB8;
  localparam logic [31:0] TORQUE_RAMP_RST        = 32'h0000_0064;
  localparam logic [15:0] TORQUE_LIMIT_RST       = 16'hFFFF;
  // -----------------------------------------------------------------
  // field positions and timing
  // -----------------------------------------------------------------
  localparam int STATUS_SPEED_MATCH_BIT = 10;
  localparam int STATUS_SPEED_OVER_BIT  = 12;
  localparam int IN_NEG_OT_BIT          = 0;
  localparam int IN_POS_OT_BIT          = 1;
  localparam int IN_HOME_BIT            = 2;
  localparam int IN_CONN_LSB            = 16;
  localparam int OUT_CONN_LSB           = 16;
  localparam int OUT_REMOTE_LSB         = 24;
  localparam int CONN_IN_COUNT          = 5;
  localparam int CONN_OUT_COUNT         = 4;
  localparam int REMOTE_COUNT           = 4;
  localparam int CLK_HZ                 = 250_000_000;
  localparam int TIME_UNIT_MS           = 1;
  localparam int MS_CYCLES              = CLK_HZ / 1000 * TIME_UNIT_MS;
  localparam int RAMP_DIV               = CLK_HZ / 1000;
  localparam logic [31:0] WRITABLE_OUT_MASK = 32'h0F0F_0000;
  // -----------------------------------------------------------------
  // carriers
  // -----------------------------------------------------------------
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } obj_req_t;
  typedef struct packed {
    logic        neg_ot;
    logic        pos_ot;
    logic        home;
    logic [4:0]  conn;
  } pin_in_t;
  typedef enum logic [1:0] {MODE_VELOCITY, MODE_PROFILE_TORQUE, MODE_CYCLIC_TORQUE, MODE_POSITION}
    mode_t;
endpackage

// >>> testbench/servo_io_master.sv
module servo_io_master (
  input  wire logic                   core_clk,
  output servo_io_pkg::obj_req_t      req,
  input  wire logic [31:0]            rdata,
  input  wire logic                   rvalid,
  input  wire logic                   rerr
);
  timeunit 1ns;
  timeprecision 1ps;
  import servo_io_pkg::*;
  // ---------------------------------------------
  // object access, one request in flight
  // ---------------------------------------------
  initial req = '0;
  task automatic wr(input logic [15:0] idx, input logic [7:0] s, input logic [31:0] d);
    @(posedge core_clk);
    req <= '{wr: 1'b1, rd: 1'b0, index: idx, sub: s, wdata: d};
    @(posedge core_clk);
    req.wr <= 1'b0;
    // released data flips so stale values never look valid
    req.wdata <= ~d;
  endtask
  task automatic rd(input logic [15:0] idx, input logic [7:0] s,
                    output logic [31:0] d, output logic e, output bit ok);
    @(posedge core_clk);
    req <= '{wr: 1'b0, rd: 1'b1, index: idx, sub: s, wdata: req.wdata};
    @(posedge core_clk);
    req.rd <= 1'b0;
    ok = 1'b0;
    for (int i = 0; i < 4 && !ok; i++) begin
      #1;
      ok = (rvalid === 1'b1);
      d = rdata;
      e = rerr;
      if (!ok) @(posedge core_clk);
    end
  endtask
endmodule

// >>> testbench/servo_velocity_torque_io_objects_sva.sv
module servo_io_chk (
  input wire logic                   core_clk,
  input wire logic                   rst_n,
  input wire servo_io_pkg::obj_req_t req,
  input wire logic [31:0]            rdata,
  input wire logic                   rvalid,
  input wire logic                   rerr,
  input wire servo_io_pkg::mode_t    mode,
  input wire logic signed [31:0]     motor_speed_in,
  input wire logic [7:0]             input_allocation_low,
  input wire logic [7:0]             input_allocation_high,
  input wire logic [3:0]             remote_output_allocation,
  input wire logic [15:0]            statusword_bits,
  input wire logic signed [15:0]     torque_command,
  input wire logic [15:0]            torque_limit_fwd,
  input wire logic [15:0]            torque_limit_rev,
  input wire logic [2:0]             internal_switches,
  input wire logic [4:0]             internal_conn_in,
  input wire logic [3:0]             remote_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import servo_io_pkg::*;
  // ---------------------------------------------
  // helpers and properties
  // ---------------------------------------------
  logic [7:0] remote_in;
  logic [3:0] alloc_r;
  logic [3:0] cause_r;
  assign remote_in = input_allocation_low | input_allocation_high;
  // a remote output may move only shortly after a write or a routing change
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      alloc_r <= 4'h0;
      cause_r <= 4'h0;
    end else begin
      alloc_r <= remote_output_allocation;
      cause_r <= {cause_r[2:0], req.wr | (alloc_r != remote_output_allocation)};
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  rd_answer_a: assert property (rvalid == $past(req.rd))
    else $error("read answer not one cycle after request");
  err_data_a: assert property (rerr |-> rvalid && rdata == 32'h0)
    else $error("error answer without zero data");
  status_rsvd_a: assert property ((statusword_bits & 16'hEBFF) == 16'h0)
    else $error("unexpected status bit set");
  over_drop_a: assert property (motor_speed_in <= 0 |=> !statusword_bits[12])
    else $error("threshold flag kept at low speed");
  sw_remote_a: assert property ($stable(remote_in) |->
    (internal_switches & remote_in[2:0]) == 3'h0)
    else $error("remote switch seen internally");
  conn_remote_a: assert property ($stable(remote_in) |->
    (internal_conn_in & remote_in[7:3]) == remote_in[7:3])
    else $error("remote connector input not inactive");
  remote_cause_a: assert property ($changed(remote_out) |-> |cause_r)
    else $error("remote output moved without cause");
  torque_fwd_a: assert property (mode != MODE_PROFILE_TORQUE && $stable(mode)
    && $stable(torque_limit_fwd) |-> int'(torque_command) <= int'(torque_limit_fwd))
    else $error("torque above forward limit");
  torque_rev_a: assert property (mode != MODE_PROFILE_TORQUE && $stable(mode)
    && $stable(torque_limit_rev) |-> int'(torque_command) >= -int'(torque_limit_rev))
    else $error("torque below reverse limit");
endmodule
bind servo_velocity_torque_io_objects servo_io_chk u_chk (.*);

// >>> testbench/servo_velocity_torque_io_objects_tb_top.sv
module servo_velocity_torque_io_objects_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import servo_io_pkg::*;
  // ---------------------------------------------
  // bench, scenarios, verdict
  // ---------------------------------------------
  logic               core_clk = 1'b0;
  logic               rst_n = 1'b0;
  obj_req_t           req;
  logic [31:0]        rdata;
  logic               rvalid, rerr;
  mode_t              mode = MODE_VELOCITY;
  logic signed [31:0] enc = 32'sh0, mot = 32'sh0, traj = 32'sh0, posl = 32'sh0;
  pin_in_t            pins = '0;
  logic [7:0]         al_lo = 8'h0, al_hi = 8'h0;
  logic [3:0]         rem_al = 4'h0, en_lo = 4'h0, inv_lo = 4'h0;
  logic [3:0]         en_hi = 4'h0, inv_hi = 4'h0;
  logic [15:0]        sw_bits, lim_f, lim_r;
  logic signed [15:0] tq;
  logic [2:0]         sws;
  logic [4:0]         cin;
  logic [3:0]         c_out, r_out;
  int                 error_cnt = 0, n_compared = 0;
  initial forever #2 core_clk = ~core_clk;
  servo_velocity_torque_io_objects uut (.core_clk, .rst_n, .req, .rdata, .rvalid, .rerr,
    .mode, .encoder_speed_in(enc), .motor_speed_in(mot), .trajectory_speed_in(traj),
    .position_loop_speed_in(posl), .pins_in(pins), .input_allocation_low(al_lo),
    .input_allocation_high(al_hi), .remote_output_allocation(rem_al),
    .bus_output_enable_low(en_lo), .bus_output_enable_high(en_hi),
    .output_invert_low(inv_lo), .output_invert_high(inv_hi), .statusword_bits(sw_bits),
    .torque_command(tq), .torque_limit_fwd(lim_f), .torque_limit_rev(lim_r),
    .internal_switches(sws), .internal_conn_in(cin), .conn_out(c_out), .remote_out(r_out));
  servo_io_master mst (.core_clk, .req, .rdata, .rvalid, .rerr);
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic rchk(input logic [15:0] idx, input logic [7:0] s, input logic [31:0] exp);
    logic [31:0] d;
    logic        e;
    bit          ok;
    mst.rd(idx, s, d, e, ok);
    if (!ok) begin
      error_cnt++;
      $display("CHECK FAILED rvalid exp 1 got 0");
      results();
    end else begin
      chk($sformatf("obj %h.%h", idx, s), exp, d);
      chk("rerr", 32'(idx == 16'h1234), 32'(e));
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic t_reset();
    logic [15:0] zi [6] = '{IDX_SPEED_MATCH_WIDTH, IDX_SPEED_MATCH_TIME, IDX_SPEED_THRESHOLD,
      IDX_SPEED_THRESH_TIME, IDX_TORQUE_SETPOINT, IDX_SPEED_SETPOINT};
    cyc(1);
    chk("conn_out", 32'hF, 32'(c_out));
    chk("lim_fwd", 32'hBB8, 32'(lim_f));
    chk("lim_rev", 32'hBB8, 32'(lim_r));
    foreach (zi[i]) rchk(zi[i], 8'h0, 32'h0);
    rchk(IDX_TORQUE_CEILING, 8'h0, 32'hBB8);
    rchk(IDX_TORQUE_RAMP_RATE, 8'h0, 32'h64);
    rchk(IDX_OUTPUT_OBJ, SUB_ENTRY_COUNT, 32'h2);
    rchk(IDX_OUTPUT_OBJ, SUB_OUTPUT_WORD, 32'h0);
    rchk(IDX_OUTPUT_OBJ, SUB_OUTPUT_MASK, 32'h0);
  endtask
  task automatic t_rw();
    @(posedge core_clk);
    enc <= 32'sh8000_0001;
    traj <= 32'sh11;
    posl <= 32'sh22;
    mot <= -32'sh5;
    mst.wr(IDX_ENCODER_SPEED, 8'h0, 32'h0);
    rchk(IDX_ENCODER_SPEED, 8'h0, 32'h8000_0001);
    rchk(IDX_MOTOR_SPEED, 8'h0, 32'hFFFF_FFFB);
    rchk(IDX_SPEED_LOOP_REF, 8'h0, 32'h11);
    @(posedge core_clk) mode <= MODE_POSITION;
    rchk(IDX_SPEED_LOOP_REF, 8'h0, 32'h22);
    mst.wr(IDX_SPEED_MATCH_WIDTH, 8'h0, 32'h0000_FFFF);
    rchk(IDX_SPEED_MATCH_WIDTH, 8'h0, 32'h0000_FFFF);
    mst.wr(IDX_OUTPUT_OBJ, SUB_ENTRY_COUNT, 32'h5);
    rchk(IDX_OUTPUT_OBJ, SUB_ENTRY_COUNT, 32'h2);
    mst.wr(IDX_OUTPUT_OBJ, SUB_OUTPUT_WORD, 32'hFFFF_FFFF);
    rchk(IDX_OUTPUT_OBJ, SUB_OUTPUT_WORD, 32'h0F0F_0000);
    rchk(16'h1234, 8'h0, 32'h0);
  endtask
  task automatic t_torque();
    mst.wr(IDX_TORQUE_CEILING, 8'h0, 32'h3E8);
    mst.wr(IDX_TORQUE_LIMIT_FWD, 8'h0, 32'h1F4);
    mst.wr(IDX_TORQUE_LIMIT_REV, 8'h0, 32'h7D0);
    @(posedge core_clk) mode <= MODE_CYCLIC_TORQUE;
    mst.wr(IDX_TORQUE_SETPOINT, 8'h0, 32'h7D0);
    cyc(2);
    chk("lim_fwd", 32'h1F4, 32'(lim_f));
    chk("lim_rev", 32'h3E8, 32'(lim_r));
    rchk(IDX_TORQUE_REF_OUT, 8'h0, 32'h1F4);
    rchk(IDX_TORQUE_FEEDBACK, 8'h0, 32'h1F4);
    mst.wr(IDX_TORQUE_SETPOINT, 8'h0, 32'h0000_8000);
    rchk(IDX_TORQUE_SETPOINT, 8'h0, 32'hFFFF_8000);
    rchk(IDX_TORQUE_REF_OUT, 8'h0, 32'hFFFF_FC18);
    // one unit per cycle keeps the ramp short
    mst.wr(IDX_TORQUE_RAMP_RATE, 8'h0, 32'h0EE6_B280);
    @(posedge core_clk) mode <= MODE_PROFILE_TORQUE;
    mst.wr(IDX_TORQUE_SETPOINT, 8'h0, 32'h0);
    cyc(20);
    chk("ramp", 32'h1, 32'(tq > -16'sh3E8 && tq < -16'sh384));
    cyc(1100);
    chk("ramp_end", 32'h0, 32'(tq));
    mst.wr(IDX_TORQUE_SETPOINT, 8'h0, 32'h7D0);
    cyc(700);
    chk("capped", 32'h1F4, 32'(tq));
  endtask
  task automatic t_io();
    @(posedge core_clk) pins <= '{neg_ot: 1'b1, pos_ot: 1'b0, home: 1'b1, conn: 5'h16};
    cyc(4);
    chk("switches", 32'h5, 32'(sws));
    chk("conn_in", 32'h16, 32'(cin));
    rchk(IDX_INPUT_WORD, 8'h0, 32'h0016_0005);
    @(posedge core_clk);
    al_hi <= 8'h01;
    al_lo <= 8'h08;
    cyc(4);
    chk("switches", 32'h4, 32'(sws));
    chk("conn_in", 32'h17, 32'(cin));
    rchk(IDX_INPUT_WORD, 8'h0, 32'h0016_0005);
    @(posedge core_clk);
    en_lo <= 4'h1;
    rem_al <= 4'hF;
    mst.wr(IDX_OUTPUT_OBJ, SUB_OUTPUT_MASK, 32'h0103_0000);
    mst.wr(IDX_OUTPUT_OBJ, SUB_OUTPUT_WORD, 32'h0F00_0000);
    cyc(3);
    chk("conn_out", 32'hE, 32'(c_out));
    chk("remote_out", 32'h1, 32'(r_out));
    @(posedge core_clk) inv_lo <= 4'h1;
    cyc(3);
    chk("conn_out", 32'hF, 32'(c_out));
    @(posedge core_clk);
    inv_hi <= 4'h1;
    en_hi  <= 4'h2;
    cyc(3);
    chk("conn_out", 32'hC, 32'(c_out));
  endtask
  task automatic t_status();
    mst.wr(IDX_SPEED_SETPOINT, 8'h0, 32'h3E8);
    mst.wr(IDX_SPEED_MATCH_WIDTH, 8'h0, 32'hA);
    mst.wr(IDX_SPEED_THRESHOLD, 8'h0, 32'h3F2);
    mst.wr(IDX_SPEED_THRESH_TIME, 8'h0, 32'h1);
    @(posedge core_clk) mot <= 32'sh3F2;
    cyc(3);
    chk("match", 32'h1, 32'(sw_bits[10]));
    chk("over", 32'h0, 32'(sw_bits[12]));
    @(posedge core_clk) mot <= 32'sh3F3;
    cyc(2);
    chk("match", 32'h0, 32'(sw_bits[10]));
    cyc(200);
    chk("over", 32'h0, 32'(sw_bits[12]));
    mst.wr(IDX_SPEED_THRESH_TIME, 8'h0, 32'h0);
    cyc(3);
    chk("over", 32'h1, 32'(sw_bits[12]));
  endtask
  task automatic results();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_rw();
    t_torque();
    t_io();
    t_status();
    results();
  end
endmodule
